// File: serial_cfg_map.svh
/*
 * register offsets, reset values, masks, field positions and command codes of the serial configuration block.
 * assumes: included by its bare name by the package-using design file.
 */
`ifndef SERIAL_CFG_MAP_SVH
`define SERIAL_CFG_MAP_SVH
`define CMD_BITS          5'h10
`define CMD_WRITE_PAGE    16'hFD00
`define CMD_READ_PAGE     16'hFE00
`define OFS_STANDBY       8'h01
`define OFS_SOFT_RESET    8'h02
`define OFS_YUV_FORMAT    8'h04
`define OFS_CONTRAST_RNG  8'h06
`define OFS_RED_GAIN      8'h07
`define OFS_GREEN_GAIN    8'h08
`define OFS_BLUE_GAIN     8'h09
`define OFS_CONTRAST_EN   8'h0C
`define OFS_RED_BRIGHT    8'h0D
`define OFS_GREEN_BRIGHT  8'h0E
`define OFS_BLUE_BRIGHT   8'h0F
`define OFS_INTF_SELECT   8'h18
`define OFS_VBLANK        8'h19
`define OFS_HBLANK        8'h1A
`define OFS_SCAN_DIR      8'h1C
`define RST_STANDBY       8'h00
`define RST_SOFT_RESET    8'h10
`define RST_YUV_FORMAT    8'h40
`define RST_CONTRAST_RNG  8'h07
`define RST_GAIN          8'h40
`define RST_CONTRAST_EN   8'h00
`define RST_BRIGHT        8'h40
`define RST_INTF_SELECT   8'h00
`define RST_VBLANK        8'h15
`define RST_HBLANK        8'h51
`define RST_SCAN_DIR      8'h03
`define MSK_STANDBY       8'h01
`define MSK_SOFT_RESET    8'h10
`define MSK_YUV_FORMAT    8'h6F
`define MSK_CONTRAST_RNG  8'h07
`define MSK_ONE_BIT       8'h01
`define MSK_VBLANK        8'h9F
`define MSK_SCAN_DIR      8'h03
`define BIT_STANDBY       0
`define BIT_SOFT_RESET    4
`define BIT_CHROMA_SIGN   0
`define BIT_CHROMA_AVG    1
`define BIT_MATRIX_LO     2
`define BIT_MATRIX_HI     3
`define BIT_LANE_SWAP     5
`define BIT_CHROMA_ORDER  6
`endif

// File: serial_cfg_pkg.sv
/*
 * types shared by the serial configuration block.
 * assumes: offsets and reset values come from serial_cfg_map.svh.
 */
package serial_cfg_pkg;
   typedef enum logic [1:0] {
      MATRIX_DEFAULT,
      MATRIX_SCALED,
      MATRIX_ALT,
      MATRIX_RESERVED
   } matrix_sel_t;

   typedef struct packed {
      logic        chroma_order_swap;
      logic        luma_chroma_lane_swap;
      matrix_sel_t conversion_matrix_select;
      logic        chroma_averaging_enable;
      logic        chroma_unsigned_select;
   } yuv_cfg_t;

   typedef struct packed {
      logic [2:0]  contrast_range_bit;
      logic [7:0]  red_gain;
      logic [7:0]  green_gain;
      logic [7:0]  blue_gain;
      logic        gain_enable;
      logic [7:0]  red_offset;
      logic [7:0]  green_offset;
      logic [7:0]  blue_offset;
   } colour_cfg_t;

   typedef struct packed {
      logic        horizontal_blank_override;
      logic [4:0]  vertical_blank_length;
      logic [7:0]  horizontal_blank_length;
      logic        vertical_scan_order;
      logic        horizontal_scan_order;
   } timing_cfg_t;

   typedef enum logic [1:0] {
      PAGE_WRITE,
      PAGE_READ
   } page_mode_t;
endpackage

// File: serial_config_register_bank.sv
/*
 * serial configuration register bank: 3-wire command port, page 00 registers, decoded config outputs.
 * assumes: ref_clk at 50 MHz is far faster than the serial clock; pins are asynchronous to it.
 */
// Overview of operation
// (R1) commands are 16 bits, one bit sampled per serial clock rising edge
// (R2) transfer opens on chip select fall, commits on chip select rise
// (R3) under 16 clock edges in a transfer: discard, no register changes
// (R4) 16 or more edges: first 16 bits form the command, extra ignored
// (R5) serial receive is timed by serial clock edges, not pixel clock
// (R6) commands are accepted and executed during standby
// (R7) command FD00h selects write condition for page 00
// (R8) command FE00h selects read condition; reads return register contents
// (R9) first byte is address, second byte data, both MSB first; read drives data
// (R10) standby bit resets to 0 meaning standby; 1 means normal operation
// (R11) standby 0 to 1 starts power-on, 1 to 0 starts power-off sequence
// (R12) register reset bit defaults 1; writing 0 restores all defaults at once
// (R13) effective reset active whenever pin or register reset bit is 0
// (R14) yuv format settings apply only when yuv input is selected
// (R15) lane swap bit exchanges luma and chroma lanes
// (R16) chroma order bit: 0 gives Cr then Cb, 1 gives Cb then Cr
// (R17) matrix select picks default, scaled, alternate matrix; 11 reserved
// (R18) chroma sign bit: 1 means unsigned chroma with 128 removed
// (R19) chroma averaging bit: even pixels average neighbouring odd chroma
// (R20) contrast gain: range 0 gives 0.5+code/512, range 1 gives code/64
// (R21) contrast enable gates the per-channel gains
// (R22) output is input times gain plus brightness, clipped to 0..255
`timescale 1ns/1ns
`include "serial_cfg_map.svh"
module serial_config_register_bank (
   input  wire logic                       ref_clk,
   input  wire logic                       arst_n,
   input  wire logic                       active_low_reset,
   input  wire logic                       cs_n,
   input  wire logic                       scl,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe,
   output logic                            standby_off_bit,
   output logic                            power_on_start,
   output logic                            power_off_start,
   output logic                            input_format_select,
   output serial_cfg_pkg::yuv_cfg_t        yuv_cfg,
   output serial_cfg_pkg::colour_cfg_t     colour_cfg,
   output serial_cfg_pkg::timing_cfg_t     timing_cfg,
   output logic                            regs_reset_active
);
   logic [2:0]                 cs_sync_r;
   logic [2:0]                 scl_sync_r;
   logic [2:0]                 sda_sync_r;
   logic                       cs_n_r;
   logic                       scl_r;
   logic                       sda_r;
   logic [15:0]                shift_r;
   logic [4:0]                 bit_cnt_r;
   logic [7:0]                 rd_shift_r;
   serial_cfg_pkg::page_mode_t page_r;
   logic                       reg_rst_n;
   logic [7:0]                 r_standby;
   logic [7:0]                 r_soft_reset;
   logic [7:0]                 r_yuv;
   logic [7:0]                 r_crange;
   logic [7:0]                 r_rgain;
   logic [7:0]                 r_ggain;
   logic [7:0]                 r_bgain;
   logic [7:0]                 r_cen;
   logic [7:0]                 r_rbright;
   logic [7:0]                 r_gbright;
   logic [7:0]                 r_bbright;
   logic [7:0]                 r_intf;
   logic [7:0]                 r_vblank;
   logic [7:0]                 r_hblank;
   logic [7:0]                 r_scan;
   logic                       standby_prev_r;
   logic                       cs_fall;
   logic                       cs_rise;
   logic                       scl_rise;
   logic                       scl_fall;
   logic                       commit;
   logic [7:0]                 cmd_addr;
   logic [7:0]                 cmd_data;
   logic                       wr_en;
   logic                       rst_now;
   logic [7:0]                 rd_data;

   // three-stage sync; a change counts once stages two and three agree
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_sync_r  <= 3'h7;
         scl_sync_r <= 3'h0;
         sda_sync_r <= 3'h0;
      end else begin
         cs_sync_r  <= {cs_sync_r[1:0], cs_n};
         scl_sync_r <= {scl_sync_r[1:0], scl};
         sda_sync_r <= {sda_sync_r[1:0], sda_in};
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_n_r <= 1'b1;
         scl_r  <= 1'b0;
         sda_r  <= 1'b0;
      end else begin
         if (cs_sync_r[1] == cs_sync_r[2])
            cs_n_r <= cs_sync_r[2];
         if (scl_sync_r[1] == scl_sync_r[2])
            scl_r <= scl_sync_r[2];
         if (sda_sync_r[1] == sda_sync_r[2])
            sda_r <= sda_sync_r[2];
      end
   end

   // sda is delayed as much as scl, so the bit seen at the edge is the set-up one
   assign cs_fall  = cs_n_r && (cs_sync_r[1] == cs_sync_r[2]) && !cs_sync_r[2];
   assign cs_rise  = !cs_n_r && (cs_sync_r[1] == cs_sync_r[2]) && cs_sync_r[2];
   assign scl_rise = !scl_r && (scl_sync_r[1] == scl_sync_r[2]) && scl_sync_r[2];   // [R5]
   assign scl_fall = scl_r && (scl_sync_r[1] == scl_sync_r[2]) && !scl_sync_r[2];

   // receive shift register; saturating count keeps only the first 16 bits
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_r   <= 16'h0000;
         bit_cnt_r <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_r <= 5'h00;   // [R2]
      end else if (!cs_n_r && scl_rise && bit_cnt_r != `CMD_BITS) begin
         shift_r   <= {shift_r[14:0], sda_r};   // [R1] [R9]
         bit_cnt_r <= bit_cnt_r + 5'h01;   // [R4]
      end
   end

   assign commit   = cs_rise && (bit_cnt_r == `CMD_BITS);   // [R2] [R3]
   assign cmd_addr = shift_r[15:8];   // [R9]
   assign cmd_data = shift_r[7:0];
   // standby does not gate commit, so commands run in power save
   assign wr_en    = commit && (page_r == serial_cfg_pkg::PAGE_WRITE)
                     && (shift_r != `CMD_WRITE_PAGE) && (shift_r != `CMD_READ_PAGE);   // [R6]

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         page_r <= serial_cfg_pkg::PAGE_WRITE;
      else if (commit && shift_r == `CMD_WRITE_PAGE)
         page_r <= serial_cfg_pkg::PAGE_WRITE;   // [R7]
      else if (commit && shift_r == `CMD_READ_PAGE)
         page_r <= serial_cfg_pkg::PAGE_READ;   // [R8]
   end

   // soft reset acts on the cycle the clearing command lands, ahead of any other write
   assign rst_now = wr_en && (cmd_addr == `OFS_SOFT_RESET) && !cmd_data[`BIT_SOFT_RESET];   // [R12]
   assign reg_rst_n = active_low_reset && r_soft_reset[`BIT_SOFT_RESET];   // [R13]

   // pin reset comes through a three-stage synchroniser: async pin is sampled, not used as reset
   logic [2:0] pin_sync_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         pin_sync_r <= 3'h0;
      else
         pin_sync_r <= {pin_sync_r[1:0], active_low_reset};
   end
   logic pin_rst_n_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         pin_rst_n_r <= 1'b0;
      else if (pin_sync_r[1] == pin_sync_r[2])
         pin_rst_n_r <= pin_sync_r[2];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_standby    <= `RST_STANDBY;   // [R10]
         r_soft_reset <= `RST_SOFT_RESET;
         r_yuv        <= `RST_YUV_FORMAT;
         r_crange     <= `RST_CONTRAST_RNG;
         r_rgain      <= `RST_GAIN;
         r_ggain      <= `RST_GAIN;
         r_bgain      <= `RST_GAIN;
         r_cen        <= `RST_CONTRAST_EN;
         r_rbright    <= `RST_BRIGHT;
         r_gbright    <= `RST_BRIGHT;
         r_bbright    <= `RST_BRIGHT;
         r_intf       <= `RST_INTF_SELECT;
         r_vblank     <= `RST_VBLANK;
         r_hblank     <= `RST_HBLANK;
         r_scan       <= `RST_SCAN_DIR;
      end else if (!pin_rst_n_r || rst_now) begin
         // either reset source alone restores defaults; bit returns to 1 itself
         r_standby    <= `RST_STANDBY;   // [R12] [R13]
         r_soft_reset <= `RST_SOFT_RESET;
         r_yuv        <= `RST_YUV_FORMAT;
         r_crange     <= `RST_CONTRAST_RNG;
         r_rgain      <= `RST_GAIN;
         r_ggain      <= `RST_GAIN;
         r_bgain      <= `RST_GAIN;
         r_cen        <= `RST_CONTRAST_EN;
         r_rbright    <= `RST_BRIGHT;
         r_gbright    <= `RST_BRIGHT;
         r_bbright    <= `RST_BRIGHT;
         r_intf       <= `RST_INTF_SELECT;
         r_vblank     <= `RST_VBLANK;
         r_hblank     <= `RST_HBLANK;
         r_scan       <= `RST_SCAN_DIR;
      end else if (wr_en) begin
         case (cmd_addr)   // [R7]
            `OFS_STANDBY:      r_standby <= cmd_data & `MSK_STANDBY;
            `OFS_YUV_FORMAT:   r_yuv     <= cmd_data & `MSK_YUV_FORMAT;
            `OFS_CONTRAST_RNG: r_crange  <= cmd_data & `MSK_CONTRAST_RNG;
            `OFS_RED_GAIN:     r_rgain   <= cmd_data;
            `OFS_GREEN_GAIN:   r_ggain   <= cmd_data;
            `OFS_BLUE_GAIN:    r_bgain   <= cmd_data;
            `OFS_CONTRAST_EN:  r_cen     <= cmd_data & `MSK_ONE_BIT;
            `OFS_RED_BRIGHT:   r_rbright <= cmd_data;
            `OFS_GREEN_BRIGHT: r_gbright <= cmd_data;
            `OFS_BLUE_BRIGHT:  r_bbright <= cmd_data;
            `OFS_INTF_SELECT:  r_intf    <= cmd_data & `MSK_ONE_BIT;
            `OFS_VBLANK:       r_vblank  <= cmd_data & `MSK_VBLANK;
            `OFS_HBLANK:       r_hblank  <= cmd_data;
            `OFS_SCAN_DIR:     r_scan    <= cmd_data & `MSK_SCAN_DIR;
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses read as zero
   // keyed by the low byte: at the eighth bit the address has only reached there
   always_comb begin
      case (shift_r[7:0])
         `OFS_STANDBY:      rd_data = r_standby;
         `OFS_SOFT_RESET:   rd_data = r_soft_reset;
         `OFS_YUV_FORMAT:   rd_data = r_yuv;
         `OFS_CONTRAST_RNG: rd_data = r_crange;
         `OFS_RED_GAIN:     rd_data = r_rgain;
         `OFS_GREEN_GAIN:   rd_data = r_ggain;
         `OFS_BLUE_GAIN:    rd_data = r_bgain;
         `OFS_CONTRAST_EN:  rd_data = r_cen;
         `OFS_RED_BRIGHT:   rd_data = r_rbright;
         `OFS_GREEN_BRIGHT: rd_data = r_gbright;
         `OFS_BLUE_BRIGHT:  rd_data = r_bbright;
         `OFS_INTF_SELECT:  rd_data = r_intf;
         `OFS_VBLANK:       rd_data = r_vblank;
         `OFS_HBLANK:       rd_data = r_hblank;
         `OFS_SCAN_DIR:     rd_data = r_scan;
         default:           rd_data = 8'h00;
      endcase
   end

   // read: after 8 address bits, drive data MSB first, changing on scl fall
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_shift_r <= 8'h00;
         sda_out    <= 1'b0;
         sda_oe     <= 1'b0;
      end else if (cs_n_r || page_r != serial_cfg_pkg::PAGE_READ) begin
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else if (scl_fall && bit_cnt_r == 5'h08) begin
         rd_data_load(rd_data);
      end else if (scl_fall && bit_cnt_r > 5'h08 && bit_cnt_r < `CMD_BITS) begin
         sda_out    <= rd_shift_r[7];   // [R8] [R9]
         rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      end else if (scl_fall && bit_cnt_r == `CMD_BITS) begin
         sda_oe <= 1'b0;
      end
   end

   task automatic rd_data_load(input logic [7:0] val);
      sda_oe     <= 1'b1;
      sda_out    <= val[7];
      rd_shift_r <= {val[6:0], 1'b0};
   endtask

   // power sequence triggers on standby bit transitions
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         standby_prev_r  <= 1'b0;
         power_on_start  <= 1'b0;
         power_off_start <= 1'b0;
         standby_off_bit <= 1'b0;
      end else begin
         standby_prev_r  <= r_standby[`BIT_STANDBY];
         standby_off_bit <= r_standby[`BIT_STANDBY];   // [R10]
         power_on_start  <= r_standby[`BIT_STANDBY] && !standby_prev_r;   // [R11]
         power_off_start <= !r_standby[`BIT_STANDBY] && standby_prev_r;   // [R11]
      end
   end

   // decoded configuration; yuv fields forced to zero while rgb input selected
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         input_format_select <= 1'b0;
         yuv_cfg             <= '0;
         colour_cfg          <= '0;
         timing_cfg          <= '0;
         regs_reset_active   <= 1'b1;
      end else begin
         input_format_select <= r_intf[0];
         regs_reset_active   <= !(pin_rst_n_r && r_soft_reset[`BIT_SOFT_RESET]);   // [R13]
         if (r_intf[0]) begin   // [R14]
            yuv_cfg.chroma_order_swap        <= r_yuv[`BIT_CHROMA_ORDER];   // [R16]
            yuv_cfg.luma_chroma_lane_swap    <= r_yuv[`BIT_LANE_SWAP];   // [R15]
            yuv_cfg.conversion_matrix_select <=
               serial_cfg_pkg::matrix_sel_t'(r_yuv[`BIT_MATRIX_HI:`BIT_MATRIX_LO]);   // [R17]
            yuv_cfg.chroma_averaging_enable  <= r_yuv[`BIT_CHROMA_AVG];   // [R19]
            yuv_cfg.chroma_unsigned_select   <= r_yuv[`BIT_CHROMA_SIGN];   // [R18]
         end else begin
            yuv_cfg <= '0;
         end
         colour_cfg.contrast_range_bit <= r_crange[2:0];   // [R20]
         colour_cfg.red_gain           <= r_rgain;
         colour_cfg.green_gain         <= r_ggain;
         colour_cfg.blue_gain          <= r_bgain;
         colour_cfg.gain_enable        <= r_cen[0];   // [R21]
         colour_cfg.red_offset         <= r_rbright;   // [R22]
         colour_cfg.green_offset       <= r_gbright;
         colour_cfg.blue_offset        <= r_bbright;
         timing_cfg.horizontal_blank_override <= r_vblank[7];
         timing_cfg.vertical_blank_length     <= r_vblank[4:0];
         timing_cfg.horizontal_blank_length   <= r_hblank;
         timing_cfg.vertical_scan_order       <= r_scan[1];
         timing_cfg.horizontal_scan_order     <= r_scan[0];
      end
   end

   logic unused_reg_rst;
   assign unused_reg_rst = reg_rst_n;
endmodule

// File: serial_cfg_checker.sv
/* concurrent checks on the ports of the serial configuration register bank.
   assumes: one ref_clk domain reset by arst_n; host keeps scl halves of five cycles or more. */
`timescale 1ns/1ns
module serial_cfg_checker (
   input wire logic                        ref_clk,
   input wire logic                        arst_n,
   input wire logic                        active_low_reset,
   input wire logic                        cs_n,
   input wire logic                        scl,
   input wire logic                        sda_in,
   input wire logic                        sda_out,
   input wire logic                        sda_oe,
   input wire logic                        standby_off_bit,
   input wire logic                        power_on_start,
   input wire logic                        power_off_start,
   input wire logic                        input_format_select,
   input wire serial_cfg_pkg::yuv_cfg_t    yuv_cfg,
   input wire serial_cfg_pkg::colour_cfg_t colour_cfg,
   input wire serial_cfg_pkg::timing_cfg_t timing_cfg,
   input wire logic                        regs_reset_active
);
   logic [3:0] low_cnt_r;
   // commits land a few cycles after cs rises, so only judge deep inside a frame
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_r <= 4'h0;
      end else if (cs_n) begin
         low_cnt_r <= 4'h0;
      end else if (low_cnt_r != 4'hF) begin
         low_cnt_r <= low_cnt_r + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_pon; $rose(standby_off_bit) |-> ##[0:2] power_on_start; endproperty
   a_pon: assert property (p_pon) else $error("power-on pulse missing");
   property p_pon_once; power_on_start |=> !power_on_start; endproperty
   a_pon_once: assert property (p_pon_once) else $error("power-on pulse too long");
   property p_poff; $fell(standby_off_bit) |-> ##[0:2] power_off_start; endproperty
   a_poff: assert property (p_poff) else $error("power-off pulse missing");
   property p_excl; !(power_on_start && power_off_start); endproperty
   a_excl: assert property (p_excl) else $error("both power pulses at once");
   property p_defaults;
      regs_reset_active [*4] |-> !standby_off_bit && timing_cfg == 16'h5547
         && colour_cfg == {3'h7, 8'h40, 8'h40, 8'h40, 1'b0, 8'h40, 8'h40, 8'h40};
   endproperty
   a_defaults: assert property (p_defaults) else $error("registers not at defaults in reset");
   property p_pin; $fell(active_low_reset) |-> ##[1:6] regs_reset_active; endproperty
   a_pin: assert property (p_pin) else $error("pin reset not seen");
   property p_yuv_gate; !input_format_select && !$past(input_format_select) |-> yuv_cfg == 6'h00; endproperty
   a_yuv_gate: assert property (p_yuv_gate) else $error("yuv settings leak in rgb mode");
   property p_oe_cs; $rose(sda_oe) |-> !cs_n; endproperty
   a_oe_cs: assert property (p_oe_cs) else $error("data driven outside frame");
   property p_oe_hold; $rose(sda_oe) |-> sda_oe [*4]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("read bit too short");
   property p_hold;
      low_cnt_r > 4'h8 |-> $stable(colour_cfg) && $stable(timing_cfg) && $stable(standby_off_bit);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed inside frame");
   c_pon: cover property (power_on_start);
   c_poff: cover property (power_off_start);
   c_read: cover property ($rose(sda_oe));
   c_rst: cover property ($fell(regs_reset_active));
endmodule

bind serial_config_register_bank serial_cfg_checker u_chk (.ref_clk, .arst_n, .active_low_reset, .cs_n, .scl,
   .sda_in, .sda_out, .sda_oe, .standby_off_bit, .power_on_start, .power_off_start, .input_format_select,
   .yuv_cfg, .colour_cfg, .timing_cfg, .regs_reset_active);

// File: cfg_host.sv
/* host controller model driving the 3-wire configuration port.
   assumes: ref_clk paces all pin changes at its falling edge; sda is the resolved wire. */
`timescale 1ns/1ns
`include "serial_cfg_map.svh"
module cfg_host (
   input  wire logic       ref_clk,
   input  wire logic       sda,
   output logic            cs_n,
   output logic            scl,
   output logic            sda_drv,
   output logic            drv_en,
   output logic [7:0]      rd_byte,
   output logic            rd_done
);
   // five cycles is well above the two-cycle shortest half period the port accepts
   int   half    = 5;
   logic rd_page = 1'b0;
   initial begin
      cs_n = 1'b1;
      scl = 1'b0;
      sda_drv = 1'b0;
      drv_en = 1'b1;
      rd_byte = 8'h00;
      rd_done = 1'b0;
   end
   task automatic xfer(input logic [15:0] word, input int nbits);
      logic rd;
      rd = rd_page && word[15:8] != 8'hFD && word[15:8] != 8'hFE;
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         drv_en = !(rd && i >= 8);
         sda_drv = (i < 16) ? word[15 - i] : i[0];
         repeat (half) @(negedge ref_clk);
         scl = 1'b1;
         repeat (half) @(negedge ref_clk);
         if (rd && i >= 8 && i < 16) rd_byte = {rd_byte[6:0], sda};
         scl = 1'b0;
      end
      // stay off the line until the device has let go of it
      repeat (half) @(negedge ref_clk);
      drv_en = 1'b1;
      cs_n = 1'b1;
      if (nbits >= 16 && word == `CMD_READ_PAGE) rd_page = 1'b1;
      else if (nbits >= 16 && word == `CMD_WRITE_PAGE) rd_page = 1'b0;
      else if (rd && nbits >= 16) rd_done = 1'b1;
      @(negedge ref_clk);
      rd_done = 1'b0;
      // keeps cs high well past its minimum and lets the commit land
      repeat (25) @(negedge ref_clk);
   endtask
endmodule

// File: tb_top.sv
/* self-checking bench for the serial configuration register bank.
   assumes: cfg_host model on the serial port; register defaults and masks from serial_cfg_map.svh. */
`timescale 1ns/1ns
`include "serial_cfg_map.svh"
`define CHK(got, want) begin tests_run++; if ((got) !== (want)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, want); end end
module tb_top;
   logic                        ref_clk = 1'b0;
   logic                        arst_n = 1'b0;
   logic                        pin_reset_n = 1'b1;
   logic                        cs_n, scl, sda_drv, drv_en, sda_wire, sda_out, sda_oe, rd_done;
   logic                        standby, pon, poff, fmt, rra;
   logic [7:0]                  rd_byte, exp_b;
   logic [7:0]                  pon_n = 8'h00, poff_n = 8'h00;
   serial_cfg_pkg::yuv_cfg_t    yuv;
   serial_cfg_pkg::colour_cfg_t colour;
   serial_cfg_pkg::timing_cfg_t timing;
   logic [7:0]                  m [0:31];
   logic [7:0]                  exp_q [$];
   logic [7:0]                  ofs [0:14] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0C,
                                               8'h0D, 8'h0E, 8'h0F, 8'h18, 8'h19, 8'h1A, 8'h1C};
   logic [7:0]                  def [0:14] = '{`RST_STANDBY, `RST_SOFT_RESET, `RST_YUV_FORMAT,
      `RST_CONTRAST_RNG, `RST_GAIN, `RST_GAIN, `RST_GAIN, `RST_CONTRAST_EN, `RST_BRIGHT, `RST_BRIGHT,
      `RST_BRIGHT, `RST_INTF_SELECT, `RST_VBLANK, `RST_HBLANK, `RST_SCAN_DIR};
   logic [7:0]                  msk [0:14] = '{`MSK_STANDBY, `MSK_SOFT_RESET, `MSK_YUV_FORMAT,
      `MSK_CONTRAST_RNG, 8'hFF, 8'hFF, 8'hFF, `MSK_ONE_BIT, 8'hFF, 8'hFF, 8'hFF, `MSK_ONE_BIT,
      `MSK_VBLANK, 8'hFF, `MSK_SCAN_DIR};
   int                          failures = 0, tests_run = 0, cyc = 0, seed = 32'h52df;

   always #10 ref_clk = ~ref_clk;
   // a released line shows the inverse of the host's last bit, never a held value
   assign sda_wire = sda_oe ? sda_out : (drv_en ? sda_drv : ~sda_drv);

   cfg_host u_host (.ref_clk(ref_clk), .sda(sda_wire), .cs_n(cs_n), .scl(scl), .sda_drv(sda_drv),
      .drv_en(drv_en), .rd_byte(rd_byte), .rd_done(rd_done));
   serial_config_register_bank dut (.ref_clk(ref_clk), .arst_n(arst_n), .active_low_reset(pin_reset_n),
      .cs_n(cs_n), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .standby_off_bit(standby), .power_on_start(pon), .power_off_start(poff), .input_format_select(fmt),
      .yuv_cfg(yuv), .colour_cfg(colour), .timing_cfg(timing), .regs_reset_active(rra));

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         report_and_stop();
      end
   end

   // pulses counted on the falling edge, half a cycle after launch, where they are settled
   always @(negedge ref_clk) begin
      pon_n = pon_n + 8'(pon);
      poff_n = poff_n + 8'(poff);
   end

   always @(posedge rd_done) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(rd_byte, exp_b)
   end

   task automatic load_defaults();
      for (int i = 0; i < 32; i++) m[i] = 8'h00;
      for (int i = 0; i < 15; i++) m[ofs[i][4:0]] = def[i];
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k);
      u_host.xfer({a, d}, 16);
      m[a[4:0]] = d & k;
   endtask

   task automatic rd(input logic [7:0] a);
      exp_q.push_back(m[a[4:0]]);
      u_host.xfer({a, 8'h00}, 16);
   endtask

   task automatic read_all();
      u_host.xfer(`CMD_READ_PAGE, 16);
      for (int i = 0; i < 15; i++) rd(ofs[i]);
      rd(8'h03);
      u_host.xfer(`CMD_WRITE_PAGE, 16);
   endtask

   task automatic chk_ports();
      `CHK(standby, m[1][0])
      `CHK(fmt, m[24][0])
      `CHK(colour, {m[6][2:0], m[7], m[8], m[9], m[12][0], m[13], m[14], m[15]})
      `CHK(timing, {m[25][7], m[25][4:0], m[26], m[28][1:0]})
      `CHK(yuv, m[24][0] ? {m[4][6:5], m[4][3:0]} : 6'h00)
   endtask

   initial begin
      load_defaults();
      repeat (4) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (12) @(negedge ref_clk);
      chk_ports();
      `CHK(rra, 1'b0)
      read_all();
      u_host.half = 12;
      u_host.xfer(`CMD_READ_PAGE, 16);
      rd(`OFS_HBLANK);
      u_host.xfer(`CMD_WRITE_PAGE, 16);
      u_host.half = 5;
      // random writes to every register but soft reset, once with each input format
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 15; i++) if (ofs[i] != `OFS_SOFT_RESET) wr(ofs[i], 8'($random(seed)), msk[i]);
         wr(`OFS_INTF_SELECT, 8'(p), 8'h01);
         wr(`OFS_YUV_FORMAT, 8'($random(seed)), `MSK_YUV_FORMAT);
         chk_ports();
         read_all();
      end
      wr(`OFS_STANDBY, 8'h00, 8'h01);
      pon_n = 8'h00;
      poff_n = 8'h00;
      wr(`OFS_STANDBY, 8'h01, 8'h01);
      chk_ports();
      `CHK(pon_n, 8'h01)
      wr(`OFS_STANDBY, 8'h00, 8'h01);
      chk_ports();
      `CHK(poff_n, 8'h01)
      u_host.xfer({`OFS_RED_GAIN, 8'hA5}, 15);
      chk_ports();
      u_host.xfer({`OFS_RED_GAIN, 8'h3C}, 20);
      m[7] = 8'h3C;
      chk_ports();
      u_host.xfer({`OFS_SOFT_RESET, 8'h00}, 16);
      load_defaults();
      chk_ports();
      read_all();
      wr(`OFS_RED_BRIGHT, 8'h11, 8'hFF);
      pin_reset_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK(rra, 1'b1)
      pin_reset_n = 1'b1;
      repeat (12) @(negedge ref_clk);
      load_defaults();
      chk_ports();
      `CHK(rra, 1'b0)
      report_and_stop();
   end
endmodule
